// >>> cmced_pkg.sv
package cmced_pkg;

   // ************************************************************
   // CRC arithmetic
   // ************************************************************
   localparam logic [31:0] CMCED_CRC_POLY = 32'h04c11db7;
   localparam logic [31:0] CMCED_CRC_INIT = 32'hffffffff;

   // ************************************************************
   // Scan instruction
   // ************************************************************
   localparam int CMCED_IR_W = 10;
   localparam logic [9:0] CMCED_STORE_SCAN_INSTR = 10'h015;

   // ************************************************************
   // Reset values and stream word kinds
   // ************************************************************
   localparam logic [31:0] CMCED_RESULT_RST = 32'h00000000;
   localparam logic [31:0] CMCED_EXPECTED_RST = 32'h00000000;
   localparam logic [1:0] CMCED_KIND_DATA = 2'h0;
   localparam logic [1:0] CMCED_KIND_FRAME_CRC = 2'h1;
   localparam logic [1:0] CMCED_KIND_FINAL_CRC = 2'h2;

   typedef enum logic [1:0] {
      CMCED_CONFIG,
      CMCED_CONFIG_ERROR,
      CMCED_USER_IDLE,
      CMCED_USER_CHECK
   } cmced_state_t;

endpackage

// >>> cmced_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: During configuration each received frame's CRC is computed and checked against the frame CRC word, stopping on a mismatch.
// R2: At the end of configuration the precomputed CRC from the stream is loaded into the 32-bit expected-value register.
// R3: In user mode the CRC of the configuration cell memory is recomputed pass after pass and compared with the expected value.
// R4: User-mode checking never stops until reset, including a low level on reconfig_request_n.
// R5: The CRC is one 32-bit calculation using the IEEE 802 32-bit generator polynomial.
// R6: crc_fault_flag is 0 for an all-zero signature and 1 for a non-zero one.
// R7: Two 32-bit registers hold the check result and the expected value, and the flag follows the check result.
// R8: The expected value is fed into the compute-and-compare step at the end of every pass.
// R9: While the store scan instruction is active the expected-value register is a 32-bit scan chain from tdi to tdo.
// R10: Scanning the expected-value register does not pause checking or user logic.
// R11: After a fault the outside system either ignores it or pulses reconfig_request_n low.
// R12: The store scan instruction uses the 10-bit code 00 0001 0101.
// R13: A raised flag stays high through the next pass and drops only after a clean pass.
// R14: With detection enabled, checking starts by itself on entering user mode.
// R15: The check result updates only at the end of each full pass, so the flag changes at most once per pass.
module cmced_top #(
   parameter int NUM_WORDS = 64
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic reconfig_request_n,
   input wire logic edc_enable,
   input wire logic cfg_valid,
   input wire logic [1:0] cfg_kind,
   input wire logic [31:0] cfg_word,
   output logic [$clog2(NUM_WORDS)-1:0] cell_addr,
   output logic cell_rd_en,
   input wire logic [31:0] cell_data,
   input wire logic [cmced_pkg::CMCED_IR_W-1:0] jtag_ir,
   input wire logic jtag_shift_dr,
   input wire logic jtag_tdi,
   output logic jtag_tdo,
   output logic config_done,
   output logic config_error,
   output logic crc_fault_flag,
   output logic [31:0] crc_check_result,
   output logic [31:0] crc_expected_value
);
   import cmced_pkg::*;

   localparam int AW = $clog2(NUM_WORDS);
   localparam logic [AW-1:0] LAST_ADDR = AW'(NUM_WORDS - 1);

   typedef struct packed {
      cmced_state_t state;
      logic [31:0] crc;
      logic [31:0] result;
      logic [31:0] expected;
      logic [AW-1:0] addr;
      logic rd_valid;
      logic rd_last;
      logic rd_en;
      logic done;
      logic error;
      logic fault;
   } cmced_regs_t;

   cmced_regs_t s_q;
   cmced_regs_t s_d;
   logic hold_rst;
   logic scan_sel;

   // ************************************************************
   // CRC step
   // ************************************************************

   // Folds one 32-bit word into the running CRC, most significant bit first.
   function automatic logic [31:0] cmced_crc_word(input logic [31:0] crc, input logic [31:0] d);
      logic [31:0] c;
      logic fb;
      c = crc;
      fb = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         fb = c[31] ^ d[i];
         c = {c[30:0], 1'b0};
         if (fb) begin
            c = c ^ CMCED_CRC_POLY;
         end
      end
      return c;
   endfunction

   // Reset is either the system reset or a reconfiguration request.
   // R4: reconfig reset
   assign hold_rst = rst | ~reconfig_request_n;
   // R12: instruction decode
   assign scan_sel = (jtag_ir == CMCED_STORE_SCAN_INSTR) & jtag_shift_dr;

   // ************************************************************
   // Next-state logic
   // ************************************************************

   // Computes the next copy of all state from the current one and the inputs.
   always_comb begin
      logic [31:0] c;
      c = 32'h00000000;
      s_d = s_q;
      s_d.rd_valid = 1'b0;
      s_d.rd_last = 1'b0;
      unique case (s_q.state)
         CMCED_CONFIG: begin
            if (cfg_valid) begin
               if (cfg_kind == CMCED_KIND_DATA) begin
                  // R5: word CRC
                  s_d.crc = cmced_crc_word(s_q.crc, cfg_word);
               end else if (cfg_kind == CMCED_KIND_FRAME_CRC) begin
                  // R1: frame check
                  if (s_q.crc != cfg_word) begin
                     s_d.error = 1'b1;
                     s_d.state = CMCED_CONFIG_ERROR;
                  end
                  s_d.crc = CMCED_CRC_INIT;
               end else if (cfg_kind == CMCED_KIND_FINAL_CRC) begin
                  // R2: store precomputed CRC
                  s_d.expected = cfg_word;
                  s_d.done = 1'b1;
                  s_d.crc = CMCED_CRC_INIT;
                  s_d.addr = '0;
                  // R14: auto start
                  s_d.state = edc_enable ? CMCED_USER_CHECK : CMCED_USER_IDLE;
               end
            end
         end
         CMCED_CONFIG_ERROR: begin
            s_d.state = CMCED_CONFIG_ERROR;
         end
         CMCED_USER_IDLE: begin
            if (edc_enable) begin
               s_d.state = CMCED_USER_CHECK;
            end
         end
         CMCED_USER_CHECK: begin
            // R3: continuous passes
            s_d.addr = (s_q.addr == LAST_ADDR) ? '0 : s_q.addr + AW'(1);
            s_d.rd_valid = 1'b1;
            s_d.rd_last = (s_q.addr == LAST_ADDR);
            if (s_q.rd_valid) begin
               c = cmced_crc_word(s_q.crc, cell_data);
               if (s_q.rd_last) begin
                  // R8: compare with stored value
                  // R15: update at pass end
                  s_d.result = c ^ s_q.expected;
                  // R6: fault from signature
                  // R13: flag held per pass
                  s_d.fault = |(c ^ s_q.expected);
                  s_d.crc = CMCED_CRC_INIT;
               end else begin
                  s_d.crc = c;
               end
            end
         end
      endcase
      // Scanning overrides the stored value but never stalls checking.
      // R9: scan chain shift
      // R10: no halt
      if (scan_sel) begin
         s_d.expected = {jtag_tdi, s_q.expected[31:1]};
      end
      // Read enable follows the next state, so the pin comes from its own flop.
      s_d.rd_en = (s_d.state == CMCED_USER_CHECK);
   end

   // ************************************************************
   // State register
   // ************************************************************

   // Registers the state copy; reset clears it except the running CRC, which is loaded with CMCED_CRC_INIT.
   always_ff @(posedge clk) begin
      if (hold_rst) begin
         s_q.state <= CMCED_CONFIG;
         s_q.crc <= CMCED_CRC_INIT;
         s_q.result <= CMCED_RESULT_RST;
         s_q.expected <= CMCED_EXPECTED_RST;
         s_q.addr <= '0;
         s_q.rd_valid <= 1'b0;
         s_q.rd_last <= 1'b0;
         s_q.rd_en <= 1'b0;
         s_q.done <= 1'b0;
         s_q.error <= 1'b0;
         s_q.fault <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs are taken straight from the state flops.
   // R7: two registers
   assign cell_addr = s_q.addr;
   assign cell_rd_en = s_q.rd_en;
   assign jtag_tdo = s_q.expected[0];
   assign config_done = s_q.done;
   assign config_error = s_q.error;
   assign crc_fault_flag = s_q.fault;
   assign crc_check_result = s_q.result;
   assign crc_expected_value = s_q.expected;

   // ************************************************************
   // Assertions
   // ************************************************************

   // R6: flag matches signature
   flag_vs_result_a: assert property (@(posedge clk) disable iff (hold_rst)
      crc_fault_flag == (crc_check_result != 32'h00000000)) // R7
      else $error("fault flag disagrees with check result");

   // R15: update only at pass end
   result_pass_end_a: assert property (@(posedge clk) disable iff (hold_rst)
      (!$past(hold_rst) && $changed(crc_check_result)) |-> $past(s_q.rd_last) && $past(s_q.rd_valid)) // R15
      else $error("check result changed outside pass end");

   // R9: scan shift
   scan_shift_a: assert property (@(posedge clk) disable iff (hold_rst)
      ($past(scan_sel) && !$past(hold_rst)) |-> crc_expected_value == {$past(jtag_tdi), $past(crc_expected_value[31:1])}) // R9
      else $error("scan chain did not shift");

   // R1: frame mismatch stops
   frame_mismatch_a: assert property (@(posedge clk) disable iff (hold_rst)
      (s_q.state == CMCED_CONFIG && cfg_valid && cfg_kind == CMCED_KIND_FRAME_CRC && s_q.crc != cfg_word)
      |=> config_error && s_q.state == CMCED_CONFIG_ERROR) // R1
      else $error("frame CRC mismatch not flagged");

   // R2: final CRC stored
   final_store_a: assert property (@(posedge clk) disable iff (hold_rst)
      (s_q.state == CMCED_CONFIG && cfg_valid && cfg_kind == CMCED_KIND_FINAL_CRC && !scan_sel)
      |=> config_done && crc_expected_value == $past(cfg_word)) // R2
      else $error("precomputed CRC not stored at end of configuration");

   // R14: auto start
   auto_start_a: assert property (@(posedge clk) disable iff (hold_rst)
      (s_q.state == CMCED_USER_IDLE && edc_enable) |=> cell_rd_en) // R14
      else $error("checking did not start with detection enabled");

   // R4: checking never stops
   keep_checking_a: assert property (@(posedge clk) disable iff (hold_rst)
      cell_rd_en |=> cell_rd_en) // R4
      else $error("user-mode checking stopped");

   // R3: address walks the memory
   addr_walk_a: assert property (@(posedge clk) disable iff (hold_rst)
      (cell_rd_en && cell_addr != LAST_ADDR) |=> cell_addr == $past(cell_addr) + AW'(1)) // R3
      else $error("cell address did not advance");

   // R10: scan does not stall the walk
   scan_no_halt_a: assert property (@(posedge clk) disable iff (hold_rst)
      (cell_rd_en && scan_sel) |=> s_q.rd_valid) // R10
      else $error("scan stalled checking");

endmodule // cmced_top

// >>> cmced_cell_mem.sv
`timescale 1ns/1ps
// ************************************************************
// Configuration cell memory seen by the checker
// ************************************************************
module cmced_cell_mem #(
   parameter int N = 4
) (
   input wire logic clk,
   input wire logic [$clog2(N)-1:0] addr,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [$clog2(N)-1:0] wr_addr,
   input wire logic [31:0] wr_data,
   output logic [31:0] data
);
   logic [31:0] mem [N];
   // Reads answer one cycle later, and an idle port inverts its output on every idle cycle.
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      data <= rd_en ? mem[addr] : ~data;
   end
endmodule // cmced_cell_mem

// >>> tb.sv
`timescale 1ns/1ps
module tb;
   import cmced_pkg::*;
   localparam int N = 4;
   logic clk = 1'b0, rst = 1'b1, rcfg_n = 1'b1, edc_en = 1'b1, cfg_valid = 1'b0, shift = 1'b0, tdi = 1'b0;
   logic wr_en = 1'b0;
   logic [1:0] cfg_kind = 2'h0, addr, wr_addr = 2'h0;
   logic [31:0] cfg_word = 32'h0, wr_data = 32'h0, cell_data, result, expv, seed = 32'h80f664ac, exp_q, d0, d1, v;
   logic [9:0] ir = 10'h000;
   logic rd_en, tdo, done, cerr, fault;
   logic [31:0] model [N];
   int errors = 0, checks = 0, cyc = 0;
   cmced_top #(.NUM_WORDS(N)) u_dut (.clk(clk), .rst(rst), .reconfig_request_n(rcfg_n), .edc_enable(edc_en),
      .cfg_valid(cfg_valid), .cfg_kind(cfg_kind), .cfg_word(cfg_word), .cell_addr(addr), .cell_rd_en(rd_en),
      .cell_data(cell_data), .jtag_ir(ir), .jtag_shift_dr(shift), .jtag_tdi(tdi), .jtag_tdo(tdo),
      .config_done(done), .config_error(cerr), .crc_fault_flag(fault), .crc_check_result(result),
      .crc_expected_value(expv));
   cmced_cell_mem #(.N(N)) u_mem (.clk(clk), .addr(addr), .rd_en(rd_en), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .data(cell_data));
   // Clock and a cycle ceiling that cuts a hang short.
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         summarize();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Folds one word into the running sum, most significant bit first.
   function automatic logic [31:0] fold(logic [31:0] c, logic [31:0] w);
      for (int i = 31; i >= 0; i--) c = (c << 1) ^ ((c[31] ^ w[i]) ? CMCED_CRC_POLY : 32'h00000000);
      return c;
   endfunction
   function automatic logic [31:0] mem_crc();
      logic [31:0] c;
      c = CMCED_CRC_INIT;
      for (int i = 0; i < N; i++) c = fold(c, model[i]);
      return c;
   endfunction
   task automatic chk(string what, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   // Leaves the strobe high so consecutive words go back to back.
   task automatic send(logic [1:0] k, logic [31:0] w);
      @(negedge clk);
      cfg_valid = 1'b1;
      cfg_kind = k;
      cfg_word = w;
   endtask
   task automatic poke(int a, logic [31:0] w);
      @(negedge clk);
      wr_en = 1'b1;
      wr_addr = a[1:0];
      wr_data = w;
      model[a] = w;
      @(negedge clk);
      wr_en = 1'b0;
   endtask
   // Lets several whole passes go by and compares the check result and the fault flag.
   task automatic check_user(string name);
      repeat (3 * N + 4) @(negedge clk);
      chk("result", mem_crc() ^ exp_q, result);
      chk("fault", {31'h0, (mem_crc() ^ exp_q) != 0}, {31'h0, fault});
      $display("test %s ended", name);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < N; i++) poke(i, rnd());
      d0 = rnd();
      d1 = rnd();
      send(CMCED_KIND_DATA, d0);
      send(CMCED_KIND_DATA, d1);
      send(CMCED_KIND_FRAME_CRC, fold(fold(CMCED_CRC_INIT, d0), d1));
      send(CMCED_KIND_FINAL_CRC, mem_crc());
      @(negedge clk);
      cfg_valid = 1'b0;
      exp_q = mem_crc();
      @(negedge clk);
      chk("done", 32'h1, {31'h0, done});
      chk("config_error", 32'h0, {31'h0, cerr});
      chk("expected", exp_q, expv);
      $display("test config ended");
      check_user("clean");
      edc_en = 1'b0;
      poke(1, model[1] ^ 32'h00010000);
      check_user("upset");
      poke(1, model[1] ^ 32'h00010000);
      check_user("repaired");
      v = rnd();
      for (int j = 0; j < 64; j++) begin
         @(negedge clk);
         // Shifting under another instruction must leave the stored value alone.
         if (j == 32) begin
            chk("expected", exp_q, expv);
         end
         ir = (j < 32) ? 10'h000 : CMCED_STORE_SCAN_INSTR;
         shift = 1'b1;
         tdi = v[j % 32];
      end
      @(negedge clk);
      shift = 1'b0;
      exp_q = v;
      chk("expected", exp_q, expv);
      chk("tdo", {31'h0, v[0]}, {31'h0, tdo});
      check_user("scan");
      @(negedge clk);
      rcfg_n = 1'b0;
      @(negedge clk);
      rcfg_n = 1'b1;
      chk("expected", 32'h0, expv);
      chk("done", 32'h0, {31'h0, done});
      send(CMCED_KIND_DATA, d0);
      send(CMCED_KIND_FRAME_CRC, ~fold(CMCED_CRC_INIT, d0));
      send(CMCED_KIND_FINAL_CRC, mem_crc());
      @(negedge clk);
      cfg_valid = 1'b0;
      @(negedge clk);
      chk("config_error", 32'h1, {31'h0, cerr});
      chk("done", 32'h0, {31'h0, done});
      $display("test reconfig ended");
      // Ends configuration with detection off, then turns it on with a wrong stored value.
      @(negedge clk);
      rcfg_n = 1'b0;
      @(negedge clk);
      rcfg_n = 1'b1;
      exp_q = mem_crc() ^ 32'h00000001;
      send(CMCED_KIND_FINAL_CRC, exp_q);
      @(negedge clk);
      cfg_valid = 1'b0;
      repeat (N) @(negedge clk);
      chk("expected", exp_q, expv);
      chk("rd_en", 32'h0, {31'h0, rd_en});
      edc_en = 1'b1;
      check_user("enable");
      summarize();
   end
endmodule // tb
